// File: verilog/itm_pkg.sv
// Constants and types shared by the interval timer design.
// What this block does
// - Rate word picks one of four decade time bases, 10 kHz to 10 Hz.
// - Period counter steps once per tick of the selected time base.
// - Modulus control word sets the number of time-base ticks per period.
// - After programming, an interrupt request is raised once every period.
// - Interrupt interval spans 200 us up to 25.6 s.
// - Interval step is one time-base period: 100 us, 1 ms, 10 ms, 100 ms.
// - Block answers exactly two consecutive I/O port addresses.
// - Upper seven I/O address bits are matched to a 7-bit address setting.
package itm_pkg;

    localparam int CLK_HZ       = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;

    // Time base rates in Hz and their periods in microseconds
    localparam int RATE0_HZ     = 10_000;
    localparam int RATE1_HZ     = 1_000;
    localparam int RATE2_HZ     = 100;
    localparam int RATE3_HZ     = 10;
    localparam int STEP0_US     = 100;
    localparam int STEP1_US     = 1_000;
    localparam int STEP2_US     = 10_000;
    localparam int STEP3_US     = 100_000;

    // Clock cycles per time-base tick
    localparam int RATE0_CYC    = CLK_HZ / RATE0_HZ;
    localparam int RATE1_CYC    = CLK_HZ / RATE1_HZ;
    localparam int RATE2_CYC    = CLK_HZ / RATE2_HZ;
    localparam int RATE3_CYC    = CLK_HZ / RATE3_HZ;
    localparam int DIV_W        = 20;

    // Interval limits in microseconds
    localparam int MIN_IVL_US   = 200;
    localparam int MAX_IVL_US   = 25_600_000;

    // I/O decode
    localparam int ADR_W        = 8;
    localparam int SW_W         = 7;
    localparam logic PORT_RATE  = 1'b0;
    localparam logic PORT_MOD   = 1'b1;

    // Modulus handling: 0 means 256 ticks, 1 is raised to 2
    localparam logic [7:0] MOD_FULL  = 8'h00;
    localparam logic [7:0] MOD_ONE   = 8'h01;
    localparam logic [7:0] LOAD_FULL = 8'hFF;
    localparam logic [7:0] LOAD_MIN  = 8'h01;
    localparam logic [7:0] CNT_ZERO  = 8'h00;
    localparam logic [7:0] CNT_STEP  = 8'h01;

    typedef enum logic [1:0] {
        RATE_10K = 2'b00,
        RATE_1K  = 2'b01,
        RATE_100 = 2'b10,
        RATE_10  = 2'b11
    } itm_rate_t;

    localparam itm_rate_t RATE_RST = RATE_10K;
    localparam logic [7:0] MOD_RST = 8'h00;

    // Reload value: ticks per period minus one
    function automatic logic [7:0] itm_reload(input logic [7:0] m);
        if (m == MOD_FULL) begin
            return LOAD_FULL;
        end else if (m == MOD_ONE) begin
            return LOAD_MIN;
        end
        return m - CNT_STEP;
    endfunction : itm_reload

endpackage : itm_pkg

// File: verilog/itm_prescaler.sv
// Time-base divider: one-cycle tick at the selected decade rate.
`timescale 1ns/100ps
module itm_prescaler
    import itm_pkg::*;
#(
    parameter int W    = DIV_W,
    parameter int LIM0 = RATE0_CYC,
    parameter int LIM1 = RATE1_CYC,
    parameter int LIM2 = RATE2_CYC,
    parameter int LIM3 = RATE3_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire itm_rate_t  rate_i,
    input  wire logic       restart_i,
    output logic            tick_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } itm_div_t;

    itm_div_t div_reg;
    itm_div_t div_next;
    logic [W-1:0] last;

    function automatic logic [W-1:0] itm_last(input itm_rate_t r);
        unique case (r)
            RATE_10K: return W'(LIM0 - 1);
            RATE_1K:  return W'(LIM1 - 1);
            RATE_100: return W'(LIM2 - 1);
            RATE_10:  return W'(LIM3 - 1);
        endcase
    endfunction : itm_last

    assign last = itm_last(rate_i);

    always_comb begin
        div_next      = div_reg;
        div_next.tick = 1'b0;
        // Restart so a new rate starts a full step, never a short one
        if (restart_i) begin
            div_next.cnt = '0;
        end else if (div_reg.cnt >= last) begin
            div_next.cnt  = '0;
            div_next.tick = 1'b1;
        end else begin
            div_next.cnt = div_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick_o = div_reg.tick;

    ////////////////////////////////////////////////////////////////////////
    cnt_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        div_reg.cnt <= last || $changed(rate_i))
        else $error("prescaler count beyond selected step");

endmodule : itm_prescaler

// File: verilog/itm_timer.sv
// Interval timer top: I/O port decode, period counter, interrupt pin.
`timescale 1ns/100ps
module itm_timer
    import itm_pkg::*;
#(
    parameter int LIM0 = RATE0_CYC,
    parameter int LIM1 = RATE1_CYC,
    parameter int LIM2 = RATE2_CYC,
    parameter int LIM3 = RATE3_CYC
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [7:0]       data_i,
    input  wire logic             out_req_n_i,
    input  wire logic [SW_W-1:0]  base_sw_i,
    output logic                  irq_o,
    output logic                  irq_oe_n_o
);

    typedef struct packed {
        itm_rate_t  rate;
        logic [7:0] modulus;
        logic [7:0] cnt;
        logic       running;
        logic       irq_n;
        logic       req_prev_n;
    } itm_state_t;

    itm_state_t st_reg;
    itm_state_t st_next;
    logic       tick;
    logic       wr_stb;
    logic       hit;
    logic       wr_rate;
    logic       wr_mod;
    logic       term;

    ////////////////////////////////////////////////////////////////////////
    // Port decode: one access per falling edge of the output request
    assign hit     = adr_i[ADR_W-1:1] == base_sw_i;
    assign wr_stb  = !out_req_n_i && st_reg.req_prev_n;
    assign wr_rate = wr_stb && hit && adr_i[0] == PORT_RATE;
    assign wr_mod  = wr_stb && hit && adr_i[0] == PORT_MOD;
    assign term    = tick && st_reg.running && st_reg.cnt == CNT_ZERO;

    itm_prescaler #(
        .W    (DIV_W),
        .LIM0 (LIM0),
        .LIM1 (LIM1),
        .LIM2 (LIM2),
        .LIM3 (LIM3)
    ) u_div (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .rate_i    (st_reg.rate),
        .restart_i (wr_rate || wr_mod),
        .tick_o    (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next            = st_reg;
        st_next.req_prev_n = out_req_n_i;
        // Any write to our ports acknowledges the pending request
        if (wr_rate || wr_mod) begin
            st_next.irq_n = 1'b1;
        end
        if (wr_rate) begin
            st_next.rate = itm_rate_t'(data_i[1:0]);
        end
        if (wr_mod) begin
            st_next.modulus = data_i;
            st_next.cnt     = itm_reload(data_i);
            st_next.running = 1'b1;
        end else if (tick && st_reg.running) begin
            if (term) begin
                st_next.cnt = itm_reload(st_reg.modulus);
            end else begin
                st_next.cnt = st_reg.cnt - CNT_STEP;
            end
        end
        // Set after the clear: a write never swallows a terminal count
        if (term) begin
            st_next.irq_n = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '{rate: RATE_RST, modulus: MOD_RST, cnt: CNT_ZERO,
                        running: 1'b0, irq_n: 1'b1, req_prev_n: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // Open-drain line: level is always low, enable is active low
    assign irq_o      = 1'b0;
    assign irq_oe_n_o = st_reg.irq_n;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    rate_apply_a: assert property (wr_rate |=>
        st_reg.rate == $past(data_i[1:0]))
        else $error("rate word not applied");
    mod_load_a: assert property (wr_mod |=>
        st_reg.modulus == $past(data_i) &&
        st_reg.cnt == itm_reload($past(data_i)) && st_reg.running)
        else $error("modulus word not loaded");
    cnt_step_a: assert property (
        tick && st_reg.running && !term && !wr_mod
        |=> st_reg.cnt == $past(st_reg.cnt) - CNT_STEP)
        else $error("counter did not step on tick");
    hold_step_a: assert property (!tick && !wr_mod |=>
        $stable(st_reg.cnt))
        else $error("counter moved without tick");
    irq_fire_a: assert property (term && !wr_mod |=>
        !irq_oe_n_o && st_reg.cnt == itm_reload(st_reg.modulus))
        else $error("terminal count missed reload or request");
    idle_quiet_a: assert property (!st_reg.running |-> irq_oe_n_o)
        else $error("request before programming");
    irq_cause_a: assert property ($fell(irq_oe_n_o) |-> $past(term))
        else $error("request without terminal count");
    min_ivl_a: assert property (st_reg.running |->
        st_reg.cnt <= itm_reload(st_reg.modulus) &&
        itm_reload(st_reg.modulus) != CNT_ZERO)
        else $error("count outside programmed interval");
    decode_a: assert property (wr_stb && !hit |=>
        $stable(st_reg.rate) && $stable(st_reg.modulus))
        else $error("foreign address changed state");
    one_shot_a: assert property (!out_req_n_i && !st_reg.req_prev_n
        |=> $stable(st_reg.rate) && $stable(st_reg.modulus) &&
        !$rose(irq_oe_n_o))
        else $error("held request taken twice");

    irq_seen_c: cover property (term ##1 !irq_oe_n_o);
    full_mod_c: cover property (wr_mod && data_i == MOD_FULL);
    slow_rate_c: cover property (wr_rate && data_i[1:0] == RATE_10);

endmodule : itm_timer

// File: testbench/itm_cpu_model.sv
// Processor side model issuing single I/O output writes.
`timescale 1ns/100ps
module itm_cpu_model
    import itm_pkg::*;
(
    input  wire logic        clk_i,
    output logic [ADR_W-1:0] adr_o,
    output logic [7:0]       data_o,
    output logic             out_req_n_o
);
    initial begin
        adr_o = '0;
        data_o = '0;
        out_req_n_o = 1'b1;
    end

    // Request low for one edge; released bus shows inverted junk
    task automatic put(input logic [ADR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        adr_o       <= a;
        data_o      <= d;
        out_req_n_o <= 1'b0;
        @(posedge clk_i);
        adr_o       <= ~a;
        data_o      <= ~d;
        out_req_n_o <= 1'b1;
    endtask : put
endmodule : itm_cpu_model

// File: testbench/itm_timer_bench.sv
// Self-checking bench for the interval timer.
`timescale 1ns/100ps
module itm_timer_bench
    import itm_pkg::*;
();
    localparam int LIM [4] = '{4, 6, 8, 10};
    logic             clk_i;
    logic             rst_i;
    logic [ADR_W-1:0] adr;
    logic [7:0]       data;
    logic             req_n;
    logic [SW_W-1:0]  base_sw;
    logic             irq;
    logic             irq_oe_n;
    int               errors;
    int               num_checks;
    int               cycles;
    int               seed;
    int               exp_q[$];

    itm_cpu_model i_cpu (.clk_i(clk_i), .adr_o(adr), .data_o(data),
        .out_req_n_o(req_n));
    itm_timer #(.LIM0(LIM[0]), .LIM1(LIM[1]), .LIM2(LIM[2]),
        .LIM3(LIM[3])) i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
        .data_i(data), .out_req_n_i(req_n), .base_sw_i(base_sw),
        .irq_o(irq), .irq_oe_n_o(irq_oe_n));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Hang guard, well above the longest planned run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            complete_run();
        end
    end

    // Interrupt pin pair: drive level, drive enable
    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin

    // Cycles from write to request, against the model's queue
    task automatic chk_ivl(input logic [15:0] got);
        logic [15:0] exp;
        exp = 16'(exp_q.pop_front());
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_ivl

    // Ticks per period from the modulus word
    function automatic int ticks(input logic [7:0] md);
        return (md == 8'h00) ? 256 : (md == 8'h01) ? 2 : int'(md);
    endfunction : ticks

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_oe_n !== 1'b0 && n < 3000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk_ivl(16'(n));
    endtask : wait_irq

    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // Program rate and modulus, then time two periods to the request
    task automatic run_ivl(input int r, input logic [7:0] md);
        i_cpu.put({base_sw, PORT_RATE}, {6'($random(seed)), 2'(r)});
        i_cpu.put({base_sw, PORT_MOD}, md);
        exp_q.push_back(ticks(md) * LIM[r] + 1);
        #1;
        chk_pin({irq, irq_oe_n}, 2'b01);
        wait_irq();
        // Rate-only write acks; count kept, so the reload must repeat
        i_cpu.put({base_sw, PORT_RATE}, {6'($random(seed)), 2'(r)});
        exp_q.push_back(ticks(md) * LIM[r] + 1);
        #1;
        chk_pin({irq, irq_oe_n}, 2'b01);
        wait_irq();
    endtask : run_ivl

    initial begin
        seed = 32'h0000_078f;
        errors = 0;
        num_checks = 0;
        cycles = 0;
        base_sw = 7'($random(seed));
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk_pin({irq, irq_oe_n}, 2'b01);
        for (int r = 0; r < 4; r++) begin
            run_ivl(r, 8'h01);
            run_ivl(r, 8'h02);
            run_ivl(r, 8'h00);
            run_ivl(r, 8'($random(seed)));
            $display("test rate %0d done", r);
        end
        // Foreign address must not acknowledge the pending request
        i_cpu.put({~base_sw, PORT_RATE}, 8'h00);
        #1;
        chk_pin({irq, irq_oe_n}, 2'b00);
        i_cpu.put({base_sw, PORT_RATE}, 8'h03);
        #1;
        chk_pin({irq, irq_oe_n}, 2'b01);
        $display("test decode done");
        // Mid-run reset: line quiet, default rate back in force
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        #1;
        chk_pin({irq, irq_oe_n}, 2'b01);
        i_cpu.put({base_sw, PORT_MOD}, 8'h03);
        exp_q.push_back(ticks(8'h03) * LIM[int'(RATE_RST)] + 1);
        #1;
        wait_irq();
        $display("test reset done");
        complete_run();
    end
endmodule : itm_timer_bench
